// [include/mbr_pkg.sv]
// package: constants and carriers for the memory bus reset and handoff block
package mbr_pkg;

  // boot region, bank enable and strobe reset values
  localparam logic [3:0] MBR_RECOVERY_RST = 4'hF;
  localparam logic [4:0] MBR_BURST_DLY_RST = 5'h1F;
  localparam logic [4:0] MBR_FIRST_DLY_RST = 5'h1F;
  localparam logic MBR_ROM_TYPE_RST = 1'h0;
  localparam logic [3:0] MBR_BANK_EN_RST = 4'h0;
  localparam logic [3:0] MBR_STROBES_OFF = 4'hF;
  localparam logic [3:0] MBR_STROBES_ON = 4'h0;

  // card timing multipliers, in units of k = speed field + 1
  localparam int MBR_CARD_ADDR_SETUP_K = 3;
  localparam int MBR_CARD_CMD_K = 3;
  localparam int MBR_CARD_HOLD_K = 1;
  localparam int MBR_CARD_WAIT_K = 2;
  localparam int MBR_CARD_ACCESS_K = 6;

  // memory operation lengths in cycles
  localparam logic [3:0] MBR_ACCESS_CYCLES = 4'h4;
  localparam logic [3:0] MBR_REFRESH_CYCLES = 4'h4;

  typedef struct packed {
    logic [3:0] recovery_count;
    logic [4:0] burst_delay;
    logic [4:0] first_access_delay;
    logic bus_width_bit;
    logic rom_type;
  } mbr_boot_cfg_s;

  typedef struct packed {
    logic [3:0] row_strobe_n;
    logic [3:0] column_strobe_n;
    logic [3:0] chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
  } mbr_mem_pins_s;

  typedef struct packed {
    logic card_enable_n;
    logic card_output_enable_n;
    logic card_write_enable_n;
    logic card_io_read_n;
    logic card_io_write_n;
  } mbr_card_pins_s;

endpackage

// [design/mbr_sync2.sv]
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module mbr_sync2 (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // level
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

// [design/mbr_card_timer.sv]
// card strobe sequencer: enable setup, command, hold, counted in units of k
`timescale 1ns/1ps
`default_nettype none
module mbr_card_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // request
  input wire logic i_start,
  input wire logic i_write,
  input wire logic i_io,
  input wire logic [4:0] i_speed,
  input wire logic i_wait_n,
  // status and pins
  output logic o_busy,
  output logic o_done,
  output mbr_pkg::mbr_card_pins_s o_pins
);
  import mbr_pkg::*;

  typedef enum logic [1:0] {MBR_C_IDLE, MBR_C_SETUP, MBR_C_CMD, MBR_C_HOLD} mbr_card_e;

  mbr_card_e st_q, st_d;
  logic [8:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic io_q, io_d;
  logic done_q, done_d;
  mbr_card_pins_s pins_q, pins_d;
  logic [8:0] k;

  assign k = {4'h0, i_speed} + 9'h001;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    io_d = io_q;
    done_d = 1'b0;
    unique case (st_q)
      MBR_C_IDLE: begin
        if (i_start) begin
          // enable leads command by 3k, also giving 3k address setup
          st_d = MBR_C_SETUP;
          cnt_d = 9'(MBR_CARD_ADDR_SETUP_K * k - 1);
          wr_d = i_write;
          io_d = i_io;
        end
      end
      MBR_C_SETUP: begin
        if (cnt_q == 9'h000) begin
          st_d = MBR_C_CMD;
          cnt_d = 9'(MBR_CARD_CMD_K * k - 1);
        end else begin
          cnt_d = cnt_q - 9'h001;
        end
      end
      MBR_C_CMD: begin
        // wait sampled only once its valid window (2k-1) has passed
        if (cnt_q != 9'h000) begin
          cnt_d = cnt_q - 9'h001;
        end else if (i_wait_n) begin
          st_d = MBR_C_HOLD;
          cnt_d = 9'(MBR_CARD_HOLD_K * k - 1);
        end
      end
      MBR_C_HOLD: begin
        if (cnt_q == 9'h000) begin
          st_d = MBR_C_IDLE;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 9'h001;
        end
      end
    endcase
    pins_d = '1;
    pins_d.card_enable_n = (st_d == MBR_C_IDLE);
    if (st_d == MBR_C_CMD) begin
      pins_d.card_output_enable_n = wr_d | io_d;
      pins_d.card_write_enable_n = ~wr_d | io_d;
      pins_d.card_io_read_n = wr_d | ~io_d;
      pins_d.card_io_write_n = ~wr_d | ~io_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= MBR_C_IDLE;
      cnt_q <= 9'h000;
      wr_q <= 1'b0;
      io_q <= 1'b0;
      done_q <= 1'b0;
      pins_q <= '1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      io_q <= io_d;
      done_q <= done_d;
      pins_q <= pins_d;
    end
  end

  assign o_busy = (st_q != MBR_C_IDLE);
  assign o_done = done_q;
  assign o_pins = pins_q;
endmodule
`default_nettype wire

// [design/mbr_top.sv]
// memory bus reset defaults, disabled-bank refresh and alternate master handoff
// Behaviour
// - power-on keeps dram off, boot slowest timing
// - boot bus width bit is inverted width pin
// - boot config resets to F, 1F, 1F, 0
// - power-on drives all strobes high
// - sleep exit holds row/column strobes low
// - both resets clear all bank enables
// - read of disabled bank runs refresh
// - grant only after pending work finishes
// - granted bus pins are released
// - request and grant stay high during tenure
// - no refresh while bus is granted
// - request drop ends grant, pins driven again
// - refresh missed during tenure runs first
// - card timing minimums in units of k
// - card enable setup/hold and wait window
`timescale 1ns/1ps
`default_nettype none
module mbr_top (
  // clock and resets
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sleep_exit,
  // boot width pin
  input wire logic i_boot_width,
  // configuration from software
  input wire logic i_bank_enable_wr,
  input wire logic [3:0] i_bank_enable_data,
  input wire logic i_alt_master_en,
  input wire logic i_self_refresh_release,
  // memory request port
  input wire logic i_mem_req,
  input wire logic i_mem_read,
  input wire logic [1:0] i_mem_bank,
  input wire logic i_refresh_tick,
  // card request port
  input wire logic i_card_req,
  input wire logic i_card_write,
  input wire logic i_card_io,
  input wire logic [4:0] i_card_speed_field,
  input wire logic i_card_wait_n,
  // alternate master handshake
  input wire logic i_bus_request,
  output logic o_bus_grant,
  output logic o_mem_pins_oe,
  // status
  output logic o_mem_ack,
  output logic o_refresh_active,
  output logic o_card_done,
  output logic [3:0] o_dram_bank_enable,
  output mbr_pkg::mbr_boot_cfg_s o_boot_region_config,
  // memory pins
  output mbr_pkg::mbr_mem_pins_s o_mem_pins,
  output mbr_pkg::mbr_card_pins_s o_card_pins
);
  import mbr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {MBR_IDLE, MBR_ACCESS, MBR_REFRESH, MBR_GRANTED,
                            MBR_CARD} mbr_state_e;

  mbr_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] bank_en_q, bank_en_d;
  mbr_boot_cfg_s cfg_q, cfg_d;
  logic self_ref_q, self_ref_d;
  logic refresh_pend_q, refresh_pend_d;
  logic grant_q, grant_d;
  logic ack_q, ack_d;
  logic refresh_q, refresh_d;
  logic oe_q, oe_d;
  mbr_mem_pins_s pins_q, pins_d;
  logic req_sync;
  logic width_sync;
  logic wait_sync;
  logic [3:0] strobes_rst;
  logic rst_any;
  logic card_start;
  logic card_busy;
  logic card_done;
  mbr_card_pins_s card_pins;

  assign rst_any = i_srst | i_sleep_exit;

  // reset strobe level: power-on parks them high, sleep exit keeps them low
  // so the drams stay in self-refresh until software lets them go
  assign strobes_rst = i_srst ? MBR_STROBES_OFF : MBR_STROBES_ON;

  //////////////////////////////////////////////////////////////////////////////
  // pins from outside are synchronised before use
  mbr_sync2 u_req_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async(i_bus_request),
    .o_sync(req_sync)
  );

  mbr_sync2 u_width_sync (
    .i_clk(i_clk),
    .i_srst(1'b0),
    .i_async(i_boot_width),
    .o_sync(width_sync)
  );

  // card wait comes from the socket; the two-cycle sync delay stays inside
  // the 3k command time, so a wait valid by 2k-1 is still seen in time
  mbr_sync2 u_wait_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async(i_card_wait_n),
    .o_sync(wait_sync)
  );

  // sleep exit parks the card strobes as well
  mbr_card_timer u_card (
    .i_clk(i_clk),
    .i_srst(rst_any),
    .i_start(card_start),
    .i_write(i_card_write),
    .i_io(i_card_io),
    .i_speed(i_card_speed_field),
    .i_wait_n(wait_sync),
    .o_busy(card_busy),
    .o_done(card_done),
    .o_pins(card_pins)
  );

  // a busy timer is never restarted; a sleep-exit reset returns it to idle
  assign card_start = (st_q == MBR_IDLE) && !refresh_pend_q && !req_sync &&
                      !i_mem_req && i_card_req && !card_busy;

  //////////////////////////////////////////////////////////////////////////////
  // configuration: reset values, then software writes
  always_comb begin
    bank_en_d = bank_en_q;
    cfg_d = cfg_q;
    self_ref_d = self_ref_q;
    if (i_bank_enable_wr) begin
      bank_en_d = i_bank_enable_data;
    end
    if (i_self_refresh_release) begin
      self_ref_d = 1'b0;
    end
    // width pin is read after release; width bit is its inverse
    cfg_d.bus_width_bit = ~width_sync;
  end

  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      bank_en_q <= MBR_BANK_EN_RST;
      cfg_q.recovery_count <= MBR_RECOVERY_RST;
      cfg_q.burst_delay <= MBR_BURST_DLY_RST;
      cfg_q.first_access_delay <= MBR_FIRST_DLY_RST;
      cfg_q.rom_type <= MBR_ROM_TYPE_RST;
      cfg_q.bus_width_bit <= ~width_sync;
      // power-on wins over sleep exit when both are high
      self_ref_q <= !i_srst;
    end else begin
      bank_en_q <= bank_en_d;
      cfg_q <= cfg_d;
      self_ref_q <= self_ref_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // arbitration: accesses, refresh, card cycles and bus handoff
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    grant_d = grant_q;
    ack_d = 1'b0;
    // a tick in the same cycle as the clear is kept pending
    refresh_pend_d = refresh_pend_q | i_refresh_tick;
    unique case (st_q)
      MBR_IDLE: begin
        if (refresh_pend_q) begin
          // owed refresh runs ahead of any stalled access
          st_d = MBR_REFRESH;
          cnt_d = MBR_REFRESH_CYCLES - 4'h1;
          refresh_pend_d = i_refresh_tick;
        end else if (i_mem_req) begin
          // a held access is already pending, so it finishes before grant
          if (i_mem_read && !bank_en_q[i_mem_bank]) begin
            st_d = MBR_REFRESH;
            cnt_d = MBR_REFRESH_CYCLES - 4'h1;
          end else begin
            st_d = MBR_ACCESS;
            cnt_d = MBR_ACCESS_CYCLES - 4'h1;
          end
        end else if (req_sync) begin
          // only a quiet idle with nothing owed reaches here
          st_d = MBR_GRANTED;
          grant_d = 1'b1;
        end else if (card_start) begin
          st_d = MBR_CARD;
        end
      end
      MBR_ACCESS, MBR_REFRESH: begin
        if (cnt_q == 4'h0) begin
          st_d = MBR_IDLE;
          ack_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      MBR_CARD: begin
        if (card_done) begin
          st_d = MBR_IDLE;
          ack_d = 1'b1;
        end
      end
      MBR_GRANTED: begin
        // ticks only set the one pending flag here; nothing is refreshed
        if (!req_sync) begin
          st_d = MBR_IDLE;
          grant_d = 1'b0;
        end
      end
    endcase
    // mastership disabled: never grant, release any tenure
    if (!i_alt_master_en && st_d == MBR_GRANTED) begin
      st_d = MBR_IDLE;
      grant_d = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags follow the state just entered
  always_comb begin
    refresh_d = (st_d == MBR_REFRESH);
    // pins float from the grant edge to the edge that drops it
    oe_d = !grant_d;
  end

  // memory pin levels follow the state just entered
  always_comb begin
    pins_d.chip_select_n = MBR_STROBES_OFF;
    pins_d.output_enable_n = 1'b1;
    pins_d.write_enable_n = 1'b1;
    pins_d.row_strobe_n = self_ref_d ? MBR_STROBES_ON : MBR_STROBES_OFF;
    pins_d.column_strobe_n = self_ref_d ? MBR_STROBES_ON : MBR_STROBES_OFF;
    if (st_d == MBR_REFRESH) begin
      pins_d.row_strobe_n = MBR_STROBES_ON;
      pins_d.column_strobe_n = MBR_STROBES_ON;
    end else if (st_d == MBR_ACCESS) begin
      pins_d.row_strobe_n = ~(4'h1 << i_mem_bank);
      pins_d.column_strobe_n = MBR_STROBES_ON;
      pins_d.output_enable_n = ~i_mem_read;
      pins_d.write_enable_n = i_mem_read;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      st_q <= MBR_IDLE;
      cnt_q <= 4'h0;
      refresh_pend_q <= 1'b0;
      grant_q <= 1'b0;
      ack_q <= 1'b0;
      refresh_q <= 1'b0;
      oe_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      refresh_pend_q <= refresh_pend_d;
      grant_q <= grant_d;
      ack_q <= ack_d;
      refresh_q <= refresh_d;
      oe_q <= oe_d;
    end
  end

  // pin register, parked by either reset
  always_ff @(posedge i_clk) begin
    if (rst_any) begin
      pins_q.row_strobe_n <= strobes_rst;
      pins_q.column_strobe_n <= strobes_rst;
      pins_q.chip_select_n <= MBR_STROBES_OFF;
      pins_q.output_enable_n <= 1'b1;
      pins_q.write_enable_n <= 1'b1;
    end else begin
      pins_q <= pins_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign o_bus_grant = grant_q;
  assign o_mem_pins_oe = oe_q;
  assign o_mem_ack = ack_q;
  assign o_refresh_active = refresh_q;
  assign o_card_done = card_done;
  assign o_dram_bank_enable = bank_en_q;
  assign o_boot_region_config = cfg_q;
  assign o_mem_pins = pins_q;
  assign o_card_pins = card_pins;
endmodule
`default_nettype wire

// [tb/mbr_top_asserts.sv]
// checker: port-level assertions for the memory bus reset and handoff block
`timescale 1ns/1ps
`default_nettype none
module mbr_top_asserts (
  // clock and resets
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sleep_exit,
  // handshake
  input wire logic i_bus_request,
  input wire logic i_alt_master_en,
  input wire logic o_bus_grant,
  input wire logic o_mem_pins_oe,
  // status and pins
  input wire logic o_refresh_active,
  input wire logic [3:0] o_dram_bank_enable,
  input wire mbr_pkg::mbr_boot_cfg_s o_boot_region_config,
  input wire mbr_pkg::mbr_mem_pins_s o_mem_pins,
  input wire mbr_pkg::mbr_card_pins_s o_card_pins
);
  import mbr_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  wire logic cmd_idle;
  assign cmd_idle = &o_card_pins[3:0];
  ////////////////////////////////////////////////////////////////////////////
  // reset checks have no disable: they watch the reset itself
  property p_por; i_srst |=> o_mem_pins == 14'h3FFF && o_card_pins == 5'h1F; endproperty
  a_por: assert property (p_por) else $error("strobes not high in reset");
  property p_slp;
    i_sleep_exit && !i_srst |=> o_mem_pins == 14'h003F && o_card_pins == 5'h1F;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep exit pin state wrong");
  property p_rst;
    (i_srst || i_sleep_exit) |=> o_dram_bank_enable == 4'h0
      && o_boot_region_config[15:2] == 14'h3FFF && !o_boot_region_config.rom_type;
  endproperty
  a_rst: assert property (p_rst) else $error("reset defaults wrong");
  ////////////////////////////////////////////////////////////////////////////
  property p_oe; disable iff (i_srst) o_bus_grant |-> !o_mem_pins_oe; endproperty
  a_oe: assert property (p_oe) else $error("pins driven while granted");
  property p_nrf; disable iff (i_srst) o_bus_grant |-> !o_refresh_active; endproperty
  a_nrf: assert property (p_nrf) else $error("refresh while granted");
  property p_cbr; disable iff (i_srst) o_refresh_active |-> o_mem_pins[13:6] == 8'h00; endproperty
  a_cbr: assert property (p_cbr) else $error("refresh without all strobes");
  property p_gnt;
    disable iff (i_srst) $rose(o_bus_grant) |-> $past(i_bus_request, 2) && i_alt_master_en;
  endproperty
  a_gnt: assert property (p_gnt) else $error("grant before synced request");
  property p_gwk; disable iff (i_srst) $rose(o_bus_grant) |-> !$past(o_refresh_active); endproperty
  a_gwk: assert property (p_gwk) else $error("grant during refresh");
  property p_ten;
    disable iff (i_srst || i_sleep_exit) o_bus_grant && i_bus_request |=> o_bus_grant;
  endproperty
  a_ten: assert property (p_ten) else $error("grant dropped in tenure");
  property p_rel;
    disable iff (i_srst) o_bus_grant && !i_bus_request |-> ##[1:4] !o_bus_grant && o_mem_pins_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("bus not returned");
  property p_set; disable iff (i_srst) $fell(o_card_pins.card_enable_n) |-> cmd_idle[*3]; endproperty
  a_set: assert property (p_set) else $error("card enable setup short");
  property p_cmd; disable iff (i_srst) $fell(cmd_idle) |-> !cmd_idle[*3]; endproperty
  a_cmd: assert property (p_cmd) else $error("card command short");
endmodule
`default_nettype wire

// [tb/mbr_alt_master.sv]
// partner model: alternate memory bus master holding the bus for a set time
`timescale 1ns/1ps
`default_nettype none
module mbr_alt_master (
  // clock and control
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_hold,
  // handshake
  input wire logic i_grant,
  output logic o_req
);
  logic [7:0] cnt;
  initial begin
    o_req = 1'b0;
    cnt = 8'h00;
  end
  // short tenure keeps dram alive without a refresh counter of our own
  always @(posedge i_clk) begin
    if (i_go && !o_req) begin
      o_req <= 1'b1;
      cnt <= 8'h00;
    end else if (o_req && i_grant) begin
      cnt <= cnt + 8'h01;
      if (cnt == i_hold) o_req <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_mbr_top.sv]
// testbench: reset defaults, disabled-bank refresh, bus handoff, card strobes
`timescale 1ns/1ps
`default_nettype none
module tb_mbr_top;
  import mbr_pkg::*;
  logic clk, srst, slp, bw, bwr, srl, mreq, mrd, tick, creq, cwr, cio, go, req, rf, men, cwt;
  logic gnt, oe, ack, rfa, cdone;
  logic [3:0] bdat, ben;
  logic [1:0] bank;
  logic [4:0] spd;
  mbr_boot_cfg_s cfg;
  mbr_mem_pins_s mp;
  mbr_card_pins_s cp;
  int err_count, checks, cyc, n;
  mbr_top i_mbr_top (.i_clk(clk), .i_srst(srst), .i_sleep_exit(slp), .i_boot_width(bw),
    .i_bank_enable_wr(bwr), .i_bank_enable_data(bdat), .i_self_refresh_release(srl),
    .i_alt_master_en(men),
    .i_mem_req(mreq), .i_mem_read(mrd), .i_mem_bank(bank), .i_refresh_tick(tick),
    .i_card_req(creq), .i_card_write(cwr), .i_card_io(cio), .i_card_speed_field(spd),
    .i_card_wait_n(cwt), .i_bus_request(req), .o_bus_grant(gnt), .o_mem_pins_oe(oe),
    .o_mem_ack(ack), .o_refresh_active(rfa), .o_card_done(cdone), .o_dram_bank_enable(ben),
    .o_boot_region_config(cfg), .o_mem_pins(mp), .o_card_pins(cp));
  mbr_alt_master i_mbr_alt_master (.i_clk(clk), .i_go(go), .i_hold(8'h10), .i_grant(gnt),
    .o_req(req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(negedge clk);
  endtask
  // read held until ack, dropped in the ack cycle
  task automatic rd(input logic [1:0] b, output logic saw);
    int t;
    saw = 1'b0;
    t = 0;
    mrd = 1'b1;
    bank = b;
    mreq = 1'b1;
    do begin
      tk(1);
      saw = saw | rfa;
      t++;
    end while (ack !== 1'b1 && t < 50);
    mreq = 1'b0;
    chk("mem ack", 16'h1, {15'h0, ack});
  endtask
  task automatic card(input logic [4:0] s, input logic w, input logic io, input int xw);
    int t, c, bad;
    logic [3:0] sel;
    sel = io ? (w ? 4'hE : 4'hD) : (w ? 4'hB : 4'h7);
    t = 0;
    c = 0;
    bad = 0;
    spd = s;
    cwr = w;
    cio = io;
    cwt = 1'b0;
    creq = 1'b1;
    do begin
      tk(1);
      t++;
      if (cp[3:0] === sel) c++;
      else if (cp[3:0] !== 4'hF) bad++;
      // wait reaches the design two edges late through its synchroniser
      cwt = (c >= 3 * (s + 1) + xw - 2);
    end while (cdone !== 1'b1 && t < 400);
    chk("card done", 16'h1, {15'h0, cdone});
    creq = 1'b0;
    cwt = 1'b1;
    chk("card command cycles", 16'(3 * (s + 1) + xw), 16'(c));
    chk("card wrong strobe", 16'h0, 16'(bad));
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    {srst, slp, bw, bwr, srl, mreq, mrd, tick, creq, cwr, cio, go} = 12'h800;
    bdat = 4'h0;
    bank = 2'h0;
    spd = 5'h00;
    men = 1'b0;
    cwt = 1'b1;
    err_count = 0;
    checks = 0;
    cyc = 0;
    tk(4);
    chk("reset pins", 16'h3FFF, {2'h0, mp});
    chk("reset card pins", 16'h001F, {11'h0, cp});
    srst = 1'b0;
    tk(3);
    chk("boot cfg", 16'hFFFE, cfg);
    chk("bank enables", 16'h0, {12'h0, ben});
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 4; b++) begin
        rd(2'(b), rf);
        chk("refresh on read", {15'h0, (p == 0) | ~bdat[b]}, {15'h0, rf});
        tk(1);
      end
      bdat = 4'h5;
      bwr = 1'b1;
      tk(1);
      bwr = 1'b0;
      tk(1);
      chk("bank write", 16'h5, {12'h0, ben});
    end
    $display("test disabled bank done");
    go = 1'b1;
    tk(1);
    go = 1'b0;
    tk(8);
    chk("grant while disabled", 16'h0, {15'h0, gnt});
    men = 1'b1;
    for (n = 0; n < 20 && gnt !== 1'b1; n++) tk(1);
    chk("grant", 16'h1, {15'h0, gnt});
    chk("pins released", 16'h0, {15'h0, oe});
    tick = 1'b1;
    tk(1);
    tick = 1'b0;
    for (n = 0; n < 60 && gnt !== 1'b0; n++) tk(1);
    for (n = 0; n < 10 && rfa !== 1'b1; n++) tk(1);
    chk("refresh after tenure", 16'h1, {15'h0, rfa});
    chk("pins driven", 16'h1, {15'h0, oe});
    tk(8);
    $display("test handoff done");
    bdat = 4'hF;
    bwr = 1'b1;
    tk(1);
    bwr = 1'b0;
    bw = 1'b1;
    slp = 1'b1;
    tk(2);
    chk("sleep pins", 16'h003F, {2'h0, mp});
    slp = 1'b0;
    tk(3);
    chk("sleep cfg", 16'hFFFC, cfg);
    chk("sleep banks", 16'h0, {12'h0, ben});
    chk("self refresh held", 16'h003F, {2'h0, mp});
    srl = 1'b1;
    tk(1);
    srl = 1'b0;
    tk(4);
    chk("strobes released", 16'h3FFF, {2'h0, mp});
    $display("test sleep exit done");
    for (int i = 0; i < 4; i++) begin
      card(5'(i), i[0], i[1], i);
      tk(1);
    end
    $display("test card done");
    results();
  end
endmodule
bind mbr_top mbr_top_asserts i_mbr_top_asserts (.i_clk(i_clk), .i_srst(i_srst),
  .i_sleep_exit(i_sleep_exit), .i_bus_request(i_bus_request),
  .i_alt_master_en(i_alt_master_en), .o_bus_grant(o_bus_grant),
  .o_mem_pins_oe(o_mem_pins_oe), .o_refresh_active(o_refresh_active),
  .o_dram_bank_enable(o_dram_bank_enable), .o_boot_region_config(o_boot_region_config),
  .o_mem_pins(o_mem_pins), .o_card_pins(o_card_pins));
`default_nettype wire
